// ===== design/tmrf_flags.sv
// interrupt enable and status flag logic of a three-channel timer, wishbone slave
//
// Contract
// R1: each channel has an 8-bit enable register, reset and standby value 40h.
// R2: software writes only 0 to enable bit 7.
// R3: enable bit 6 is read-only and always reads 1.
// R4: channels 1 and 2: enable bit 5 gates underflow request, reset 0.
// R5: channel 0: bit 5 of enable and status reads 0, writes ignored.
// R6: every channel: enable bit 4 gates the overflow request.
// R7: channel 0: enable bits 3 and 2 gate flag D and C requests.
// R8: channels 1 and 2: bits 3 and 2 of both registers read 0, fixed.
// R9: every channel: enable bits 1 and 0 gate flag B and A requests.
// R10: each channel has an 8-bit status register, reset and standby value C0h; here bit 7 of channels 1 and 2 follows DIR_UP_IN instead.
// R11: status flags accept only a written 0 to clear; 1 never sets.
// R12: software clear needs a 0 write after the flag was read as 1.
// R13: channels 1 and 2: status bit 7 shows direction, 1 up, reset 1; here bit 7 follows DIR_UP_IN and reset does not force it.
// R14: channel 0 status bit 7 reads 1; status bit 6 always reads 1.
// R15: channels 1 and 2 in phase counting: underflow sets on 0000h to FFFFh.
// R16: every channel: overflow sets on counter wrap FFFFh to 0000h.
// R17: channel 0 flag D sets on counter match in compare mode.
// R18: channel 0 flag D sets on capture strobe in capture mode.
// R19: flag D clears when its request starts the transfer controller, disable-select 0.
// R20: flag C exists in channel 0 only, as status bit 2.
// R21: flags A, B, C set on compare match or capture transfer.
// R22: flags A, B, C clear when their request starts transfer controller, disable-select 0.
// R23: flag A also clears when its request starts dma with transfer enable 1.
// R24: each request is high while its flag and its enable are both 1.
`include "tmrf_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module tmrf_flags (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic HW_STANDBY_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic [15:0] COUNT_IN [3],
  input wire logic [2:0] PHASE_MODE_IN,
  input wire logic [2:0] DIR_UP_IN,
  input wire logic [3:0] MATCH_IN [3],
  input wire logic [3:0] CAPTURE_IN [3],
  input wire logic [3:0] CAPTURE_MODE_IN [3],
  input wire logic [3:0] XFER_CTRL_START_IN [3],
  input wire logic [3:0] XFER_IRQ_DISABLE_SEL_IN [3],
  input wire logic [2:0] DMA_CTRL_START_IN,
  input wire logic [2:0] DMA_XFER_ENABLE_IN,
  output logic [2:0] CMP_CAP_A_IRQ_OUT,
  output logic [2:0] CMP_CAP_B_IRQ_OUT,
  output logic CMP_CAP_C_IRQ_OUT,
  output logic CMP_CAP_D_IRQ_OUT,
  output logic [2:0] OVERFLOW_IRQ_OUT,
  output logic [2:0] UNDERFLOW_IRQ_OUT
);

  logic standby_meta_q;
  logic standby_q;
  logic clear_all;
  tmrf_pkg::tmrf_bus_t bus_q;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  tmrf_pkg::tmrf_bits_t en_q [3];
  tmrf_pkg::tmrf_bits_t flag_q [3];
  tmrf_pkg::tmrf_bits_t armed_q [3];
  tmrf_pkg::tmrf_bits_t set_ev [3];
  tmrf_pkg::tmrf_bits_t hw_clr [3];
  tmrf_pkg::tmrf_bits_t sw_clr [3];
  tmrf_pkg::tmrf_bits_t irq [3];
  logic [15:0] count_prev_q [3];
  logic [2:0] hit_ier;
  logic [2:0] hit_sts;
  logic [7:0] ier_view [3];
  logic [7:0] sts_view [3];

  // standby is a pin: two flops before anything reads it
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
    begin
      standby_meta_q <= 1'b0;
      standby_q <= 1'b0;
    end
    else
    begin
      standby_meta_q <= HW_STANDBY_IN;
      standby_q <= standby_meta_q;
    end
  end

  assign clear_all = !RST_N_IN || standby_q;

  // one access per request; ack drops at the first clock-enabled edge after it is given
  assign bus_req = WB_CYC_IN && WB_STB_IN && (bus_q == tmrf_pkg::TMRF_BUS_IDLE) && CE_IN;
  assign bus_wr = bus_req && WB_WE_IN && WB_SEL_IN[0];
  assign bus_rd = bus_req && !WB_WE_IN;

  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
      bus_q <= tmrf_pkg::TMRF_BUS_IDLE;
    else if (CE_IN)
    begin
      case (bus_q)
        tmrf_pkg::TMRF_BUS_IDLE:
          if (bus_req)
            bus_q <= tmrf_pkg::TMRF_BUS_ACK;
        tmrf_pkg::TMRF_BUS_ACK:
          bus_q <= tmrf_pkg::TMRF_BUS_IDLE;
        default:
          bus_q <= tmrf_pkg::TMRF_BUS_IDLE;
      endcase
    end
  end

  assign WB_ACK_OUT = (bus_q == tmrf_pkg::TMRF_BUS_ACK);

  assign hit_ier[0] = WB_ADR_IN == `TMRF_OFS_IER0;
  assign hit_ier[1] = WB_ADR_IN == `TMRF_OFS_IER1;
  assign hit_ier[2] = WB_ADR_IN == `TMRF_OFS_IER2;
  assign hit_sts[0] = WB_ADR_IN == `TMRF_OFS_STS0;
  assign hit_sts[1] = WB_ADR_IN == `TMRF_OFS_STS1;
  assign hit_sts[2] = WB_ADR_IN == `TMRF_OFS_STS2;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++)
    begin : g_ch
      localparam tmrf_pkg::tmrf_bits_t MASK = (ch == 0) ? `TMRF_MASK_CH0 : `TMRF_MASK_CH12;
      logic ovf_ev;
      logic unf_ev;

      // wrap detection against the previous counter value
      always_ff @(posedge MCLK_IN)
      begin
        if (clear_all)
          count_prev_q[ch] <= `TMRF_CNT_MIN;
        else if (CE_IN)
          count_prev_q[ch] <= COUNT_IN[ch];
      end

      assign ovf_ev = count_prev_q[ch] == `TMRF_CNT_MAX && COUNT_IN[ch] == `TMRF_CNT_MIN; // R16
      assign unf_ev = PHASE_MODE_IN[ch] && count_prev_q[ch] == `TMRF_CNT_MIN
        && COUNT_IN[ch] == `TMRF_CNT_MAX; // R15

      // capture mode picks the capture strobe, else the compare match
      assign set_ev[ch][3:0] = (CAPTURE_MODE_IN[ch] & CAPTURE_IN[ch])
        | (~CAPTURE_MODE_IN[ch] & MATCH_IN[ch]); // R17 R18 R21
      assign set_ev[ch][`TMRF_BIT_OVF] = ovf_ev;
      assign set_ev[ch][`TMRF_BIT_UNF] = unf_ev;

      assign hw_clr[ch][3:0] = XFER_CTRL_START_IN[ch] & ~XFER_IRQ_DISABLE_SEL_IN[ch]
        | {3'h0, DMA_CTRL_START_IN[ch] & DMA_XFER_ENABLE_IN[ch]}; // R19 R22 R23
      assign hw_clr[ch][5:4] = 2'h0;

      // a 0 only clears a flag already seen as 1 by a read
      assign sw_clr[ch] = (bus_wr && hit_sts[ch]) ? (~WB_DAT_IN[5:0] & armed_q[ch]) : 6'h00; // R11 R12

      always_ff @(posedge MCLK_IN)
      begin
        if (clear_all)
          en_q[ch] <= 6'h00; // R1
        else if (CE_IN && bus_wr && hit_ier[ch])
          en_q[ch] <= WB_DAT_IN[5:0] & MASK; // R5 R8
      end

      // set wins over a software or transfer clear in the same cycle; reset and standby (clear_all) win over set
      always_ff @(posedge MCLK_IN)
      begin
        if (clear_all)
          flag_q[ch] <= 6'h00; // R10
        else if (CE_IN)
          flag_q[ch] <= MASK & (set_ev[ch] | (flag_q[ch] & ~sw_clr[ch] & ~hw_clr[ch])); // R5 R8 R20
      end

      always_ff @(posedge MCLK_IN)
      begin
        if (clear_all)
          armed_q[ch] <= 6'h00;
        else if (CE_IN && bus_req && hit_sts[ch])
          armed_q[ch] <= WB_WE_IN ? 6'h00 : flag_q[ch]; // R12
      end

      assign irq[ch] = flag_q[ch] & en_q[ch]; // R4 R6 R7 R9 R24

      // bit 7 of the enable register keeps no state; software only writes 0 there
      assign ier_view[ch] = {1'b0, 1'b1, en_q[ch]}; // R2 R3
      assign sts_view[ch] = {(ch == 0) ? 1'b1 : DIR_UP_IN[ch], 1'b1, flag_q[ch]}; // R13 R14

      assign CMP_CAP_A_IRQ_OUT[ch] = irq[ch][`TMRF_BIT_A];
      assign CMP_CAP_B_IRQ_OUT[ch] = irq[ch][`TMRF_BIT_B];
      assign OVERFLOW_IRQ_OUT[ch] = irq[ch][`TMRF_BIT_OVF];
      assign UNDERFLOW_IRQ_OUT[ch] = irq[ch][`TMRF_BIT_UNF];

      chk_ovf_set: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        CE_IN && ovf_ev |=> flag_q[ch][`TMRF_BIT_OVF]) // R16
        else $error("overflow flag not set after wrap");

      chk_clr_needs_read: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        CE_IN && flag_q[ch][`TMRF_BIT_OVF] && !armed_q[ch][`TMRF_BIT_OVF]
        |=> flag_q[ch][`TMRF_BIT_OVF]) // R12
        else $error("overflow flag cleared without prior read");

      chk_one_never_sets: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        CE_IN && !flag_q[ch][`TMRF_BIT_A] && !set_ev[ch][`TMRF_BIT_A]
        && bus_wr && hit_sts[ch] && WB_DAT_IN[`TMRF_BIT_A]
        |=> !flag_q[ch][`TMRF_BIT_A]) // R11
        else $error("writing 1 set flag a");

      chk_irq_gated: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        OVERFLOW_IRQ_OUT[ch] |-> flag_q[ch][`TMRF_BIT_OVF] && en_q[ch][`TMRF_BIT_OVF]) // R6
        else $error("overflow request without flag and enable");

      chk_a_set: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        CE_IN && set_ev[ch][`TMRF_BIT_A] |=> flag_q[ch][`TMRF_BIT_A]) // R21
        else $error("flag a not set by event");

      chk_b_set: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        CE_IN && set_ev[ch][`TMRF_BIT_B] |=> flag_q[ch][`TMRF_BIT_B]) // R21
        else $error("flag b not set by event");

      chk_ovf_irq_level: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        OVERFLOW_IRQ_OUT[ch] == (flag_q[ch][`TMRF_BIT_OVF] && en_q[ch][`TMRF_BIT_OVF])) // R24
        else $error("overflow request level wrong");

      chk_a_irq_level: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        CMP_CAP_A_IRQ_OUT[ch] == (flag_q[ch][`TMRF_BIT_A] && en_q[ch][`TMRF_BIT_A])) // R9
        else $error("flag a request level wrong");

      chk_b_irq_level: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        CMP_CAP_B_IRQ_OUT[ch] == (flag_q[ch][`TMRF_BIT_B] && en_q[ch][`TMRF_BIT_B])) // R9
        else $error("flag b request level wrong");

      // a same-cycle set keeps the flag, so only event-free starts are checked
      chk_xfer_clear_a: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        CE_IN && XFER_CTRL_START_IN[ch][0] && !XFER_IRQ_DISABLE_SEL_IN[ch][0] && !set_ev[ch][`TMRF_BIT_A]
        |=> !flag_q[ch][`TMRF_BIT_A]) // R22
        else $error("flag a not cleared by transfer start");

      chk_sts_bit6: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        sts_view[ch][`TMRF_BIT_ONE] && ier_view[ch][`TMRF_BIT_ONE]) // R3 R14
        else $error("bit 6 not read as one");

      chk_ier_bit7: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        !ier_view[ch][`TMRF_BIT_DIR]) // R2
        else $error("enable bit 7 not zero");

      chk_unused_bits: assert property (@(posedge MCLK_IN) disable iff (clear_all)
        (flag_q[ch] & ~MASK) == 6'h00 && (en_q[ch] & ~MASK) == 6'h00) // R5 R8
        else $error("reserved bit held state");
    end
  endgenerate

  assign CMP_CAP_C_IRQ_OUT = irq[0][`TMRF_BIT_C];
  assign CMP_CAP_D_IRQ_OUT = irq[0][`TMRF_BIT_D];

  // unmapped addresses read zero and swallow writes
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    for (int i = 0; i < 3; i++)
    begin
      if (hit_ier[i])
        rdata_d = {24'h00_0000, ier_view[i]};
      if (hit_sts[i])
        rdata_d = {24'h00_0000, sts_view[i]};
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_N_IN)
      rdata_q <= 32'h0000_0000;
    else if (bus_rd)
      rdata_q <= rdata_d;
  end

  assign WB_DAT_OUT = rdata_q;

  chk_reset_vals: assert property (@(posedge MCLK_IN)
    !RST_N_IN |=> ier_view[1] == `TMRF_IER_RESET && sts_view[0] == `TMRF_STS_RESET) // R1 R10
    else $error("reset values wrong");

  chk_ch0_bit5: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    !en_q[0][`TMRF_BIT_UNF] && !flag_q[0][`TMRF_BIT_UNF] && !UNDERFLOW_IRQ_OUT[0]) // R5
    else $error("channel 0 bit 5 not zero");

  chk_ier_bit6: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    bus_rd && (hit_ier[1] || hit_ier[2]) |=> WB_ACK_OUT && WB_DAT_OUT[6] && !WB_DAT_OUT[3]) // R3 R8
    else $error("enable readback bits 6 or 3 wrong");

  chk_unf_set: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    CE_IN && PHASE_MODE_IN[2] && count_prev_q[2] == `TMRF_CNT_MIN
    && COUNT_IN[2] == `TMRF_CNT_MAX |=> ##1 flag_q[2][`TMRF_BIT_UNF] || $past(sw_clr[2][`TMRF_BIT_UNF], 1)) // R15
    else $error("underflow flag not set");

  chk_dir_read: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    bus_rd && hit_sts[1] |=> WB_DAT_OUT[7] == $past(DIR_UP_IN[1])) // R13
    else $error("direction bit readback wrong");

  chk_dma_clear: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    CE_IN && DMA_CTRL_START_IN[2] && DMA_XFER_ENABLE_IN[2] && !set_ev[2][`TMRF_BIT_A]
    |=> !flag_q[2][`TMRF_BIT_A]) // R23
    else $error("flag a not cleared by dma start");

  chk_d_set: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    CE_IN && set_ev[0][`TMRF_BIT_D] |=> flag_q[0][`TMRF_BIT_D]) // R17 R18
    else $error("flag d not set by event");

  chk_c_set: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    CE_IN && set_ev[0][`TMRF_BIT_C] |=> flag_q[0][`TMRF_BIT_C]) // R20 R21
    else $error("flag c not set by event");

  chk_c_irq_level: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    CMP_CAP_C_IRQ_OUT == (flag_q[0][`TMRF_BIT_C] && en_q[0][`TMRF_BIT_C])) // R7
    else $error("flag c request level wrong");

  chk_d_xfer_clear: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    CE_IN && XFER_CTRL_START_IN[0][3] && !XFER_IRQ_DISABLE_SEL_IN[0][3] && !set_ev[0][`TMRF_BIT_D]
    |=> !flag_q[0][`TMRF_BIT_D]) // R19
    else $error("flag d not cleared by transfer start");

  // ack may stretch only while the clock enable freezes the bus
  chk_ack_pulse: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    CE_IN && WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");

  chk_ch0_dir: assert property (@(posedge MCLK_IN) disable iff (clear_all)
    sts_view[0][`TMRF_BIT_DIR]) // R14
    else $error("channel 0 status bit 7 not one");

  chk_standby_clear: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    standby_q |=> en_q[1] == 6'h00 && flag_q[1] == 6'h00) // R1 R10
    else $error("standby did not clear channel 1");

endmodule

`default_nettype wire

// ===== design/tmrf_pkg.sv
// types shared by the timer flag block
package tmrf_pkg;
  typedef logic [5:0] tmrf_bits_t;
  typedef enum logic [1:0] {
    TMRF_BUS_IDLE = 2'b01,
    TMRF_BUS_ACK = 2'b10
  } tmrf_bus_t;
endpackage

// ===== design/tmrf_regs.svh
// register offsets, field positions, masks and reset values of the timer flag block
`ifndef TMRF_REGS_SVH
`define TMRF_REGS_SVH

`define TMRF_OFS_IER0 8'h00
`define TMRF_OFS_IER1 8'h04
`define TMRF_OFS_IER2 8'h08
`define TMRF_OFS_STS0 8'h0C
`define TMRF_OFS_STS1 8'h10
`define TMRF_OFS_STS2 8'h14

`define TMRF_IER_RESET 8'h40
`define TMRF_STS_RESET 8'hC0

`define TMRF_BIT_A 0
`define TMRF_BIT_B 1
`define TMRF_BIT_C 2
`define TMRF_BIT_D 3
`define TMRF_BIT_OVF 4
`define TMRF_BIT_UNF 5
`define TMRF_BIT_ONE 6
`define TMRF_BIT_DIR 7

`define TMRF_MASK_CH0 6'h1F
`define TMRF_MASK_CH12 6'h33

`define TMRF_CNT_MAX 16'hFFFF
`define TMRF_CNT_MIN 16'h0000

`endif

// ===== dv/tmrf_flags_bench.sv
// self-checking bench of the timer flag block
`include "tmrf_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tmrf_flags_bench;
  logic clk, rst_n, ce, sb, cyc, stb, we, ack, c_irq, d_irq, go;
  logic [7:0] adr, rd, w;
  logic [31:0] dwr, drd;
  logic [2:0] phase, dir, dma, dmae, a_irq, b_irq, v_irq, u_irq;
  logic [3:0] lag;
  logic [15:0] cnt [3];
  logic [3:0] mat [3], cap [3], capm [3], xs [3], xd [3];
  int err_total, comparisons, c;
  integer seed;
  tmrf_flags u_tmrf_flags (.MCLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .HW_STANDBY_IN(sb),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF),
    .WB_DAT_IN(dwr), .WB_DAT_OUT(drd), .WB_ACK_OUT(ack), .COUNT_IN(cnt), .PHASE_MODE_IN(phase),
    .DIR_UP_IN(dir), .MATCH_IN(mat), .CAPTURE_IN(cap), .CAPTURE_MODE_IN(capm),
    .XFER_CTRL_START_IN(xs), .XFER_IRQ_DISABLE_SEL_IN(xd), .DMA_CTRL_START_IN(dma),
    .DMA_XFER_ENABLE_IN(dmae), .CMP_CAP_A_IRQ_OUT(a_irq), .CMP_CAP_B_IRQ_OUT(b_irq),
    .CMP_CAP_C_IRQ_OUT(c_irq), .CMP_CAP_D_IRQ_OUT(d_irq), .OVERFLOW_IRQ_OUT(v_irq),
    .UNDERFLOW_IRQ_OUT(u_irq));
  tmrf_irq_partner u_tmrf_irq_partner (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .lag_in(lag),
    .irq_a_in(a_irq), .xfer_start_out(xs), .disable_sel_out(xd), .dma_start_out(dma),
    .dma_enable_out(dmae));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle; waits on ack, bounded so a dead slave cannot hang
  task automatic wb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dwr <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    chk({31'h0, ack}, 32'h1);
    rd = drd[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk({24'h0, rd}, {24'h0, e});
  endtask
  task automatic ev(input int ch, input logic [3:0] m, input logic [3:0] p);
    @(posedge clk);
    mat[ch] <= m;
    cap[ch] <= p;
    @(posedge clk);
    mat[ch] <= 4'h0;
    cap[ch] <= 4'h0;
  endtask
  function automatic logic [7:0] ier_exp(input int ch, input logic [7:0] v);
    return `TMRF_IER_RESET | (v & (ch == 0 ? 8'h1F : 8'h33));
  endfunction
  initial
  begin
    #(8 * 5000);
    err_total++;
    give_verdict();
  end
  initial
  begin
    seed = 32'h8D8B31C1;
    {rst_n, sb, cyc, stb, we, go, phase, adr, dwr} = '0;
    {ce, dir, lag} = {1'b1, 3'b111, 4'h1};
    cnt = '{default: 16'h0};
    mat = '{default: 4'h0};
    cap = '{default: 4'h0};
    capm = '{default: 4'h0};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
      rc(8'(i * 4), i < 3 ? 8'h40 : 8'hC0);
    rc(8'h18, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 12; i++)
    begin
      c = i % 3;
      w = i > 8 ? 8'h7F : 8'($random(seed)) & 8'h7F;
      wb(1'b1, 8'(c * 4), w);
      rc(8'(c * 4), ier_exp(c, w));
    end
    $display("enable masks done");
    capm[0] <= 4'h8;
    ev(0, 4'hF, 4'h0);
    rc(8'h0C, 8'hC7);
    ev(0, 4'h0, 4'h8);
    ev(1, 4'h3, 4'h0);
    rc(8'h0C, 8'hCF);
    chk({a_irq, b_irq, c_irq, d_irq}, 8'b01101111);
    wb(1'b1, 8'h00, 8'h13);
    chk({c_irq, d_irq}, 2'b00);
    $display("compare capture done");
    // ones never set, a write without a fresh read of 1 never clears
    wb(1'b1, 8'h0C, 8'hFF);
    wb(1'b1, 8'h0C, 8'h00);
    rc(8'h0C, 8'hCF);
    wb(1'b1, 8'h0C, 8'hF7);
    rc(8'h0C, 8'hC7);
    wb(1'b1, 8'h0C, 8'h00);
    rc(8'h0C, 8'hC0);
    wb(1'b1, 8'h0C, 8'hFF);
    rc(8'h0C, 8'hC0);
    $display("flag clearing done");
    @(posedge clk);
    phase <= 3'b110;
    cnt <= '{default: 16'hFFFF};
    @(posedge clk);
    cnt <= '{default: 16'h0000};
    rc(8'h0C, 8'hD0);
    rc(8'h10, 8'hF3);
    rc(8'h14, 8'hF0);
    chk({v_irq, u_irq}, 6'b111110);
    wb(1'b1, 8'h08, 8'h13);
    chk(u_irq, 3'b010);
    dir <= 3'b101;
    rc(8'h10, 8'h73);
    $display("wrap and direction done");
    lag <= 4'(($random(seed) & 7) + 1);
    go <= 1'b1;
    ev(0, 4'h1, 4'h0);
    ev(2, 4'h1, 4'h0);
    for (int n = 0; n < 40 && a_irq !== 3'b000; n++)
      @(posedge clk);
    chk(a_irq, 3'b000);
    rc(8'h0C, 8'hD0);
    rc(8'h10, 8'h72);
    rc(8'h14, 8'hF0);
    $display("transfer clear done");
    // events while the clock enable is low must leave every flag alone
    @(posedge clk);
    ce <= 1'b0;
    ev(0, 4'h2, 4'h0);
    ce <= 1'b1;
    rc(8'h0C, 8'hD0);
    $display("clock enable done");
    sb <= 1'b1;
    repeat (4) @(posedge clk);
    sb <= 1'b0;
    rc(8'h04, 8'h40);
    rc(8'h10, 8'h40);
    $display("standby done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== dv/tmrf_irq_partner.sv
// interrupt acceptor model: transfer controller and dma answering flag a requests
`timescale 1ns/1ns
`default_nettype none
module tmrf_irq_partner (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic go_in,
  input wire logic [3:0] lag_in,
  input wire logic [2:0] irq_a_in,
  output logic [3:0] xfer_start_out [3],
  output logic [3:0] disable_sel_out [3],
  output logic [2:0] dma_start_out,
  output logic [2:0] dma_enable_out
);
  logic [3:0] wait_q;
  // disable-select kept 0, so every start must clear its flag
  assign disable_sel_out = '{default: 4'h0};
  assign dma_enable_out = 3'b100;
  always_ff @(posedge clk_in)
  begin
    xfer_start_out <= '{default: 4'h0};
    dma_start_out <= 3'b000;
    if (!rst_n_in || !go_in || irq_a_in == 3'b000)
      wait_q <= 4'h0;
    else if (wait_q < lag_in)
      wait_q <= wait_q + 4'h1;
    else
    begin
      // lag of at least 1 avoids a second start on a stale request
      xfer_start_out[0][0] <= irq_a_in[0];
      xfer_start_out[1][0] <= irq_a_in[1];
      dma_start_out[2] <= irq_a_in[2];
      wait_q <= 4'h0;
    end
  end
endmodule
`default_nettype wire
